// *** common/flash_front_pkg.sv ***
// shared constants and types for the serial flash instruction front end
package flash_front_pkg;
  // instruction codes
  localparam logic [7:0] CMD_WEN = 8'h06;
  localparam logic [7:0] CMD_WDI = 8'h04;
  localparam logic [7:0] CMD_VWEN = 8'h50;
  localparam logic [7:0] CMD_RSR1 = 8'h05;
  localparam logic [7:0] CMD_RSR2 = 8'h35;
  localparam logic [7:0] CMD_RSR3 = 8'h15;
  localparam logic [7:0] CMD_WSR1 = 8'h01;
  localparam logic [7:0] CMD_WSR2 = 8'h31;
  localparam logic [7:0] CMD_WSR3 = 8'h11;
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_FAST = 8'h0B;
  localparam logic [7:0] CMD_DUAL = 8'h3B;
  localparam logic [7:0] CMD_QUAD = 8'h6B;
  // status bit positions and writable masks
  localparam int BIT_BUSY = 0;
  localparam int BIT_LATCH = 1;
  localparam int BIT_REG_LOCK = 0;
  localparam int BIT_QUAD = 1;
  localparam logic [7:0] LOCK_MASK = 8'h38;
  localparam logic [7:0] WR_MASK1 = 8'h7C;
  localparam logic [7:0] WR_MASK2 = 8'h7B;
  localparam logic [7:0] WR_MASK3 = 8'h64;
  // bit counts within a frame
  localparam logic [4:0] LAST_CMD_BIT = 5'h07;
  localparam logic [4:0] LAST_ADDR_BIT = 5'h17;
  localparam logic [4:0] LAST_DUMMY = 5'h07;
  localparam logic [4:0] ONE_BYTE = 5'h08;
  localparam logic [4:0] TWO_BYTES = 5'h10;
  // output lane widths and enables (enable low = driven)
  localparam logic [2:0] LANES_1 = 3'h1;
  localparam logic [2:0] LANES_2 = 3'h2;
  localparam logic [2:0] LANES_4 = 3'h4;
  localparam logic [3:0] OE_N_NONE = 4'hF;
  localparam logic [3:0] OE_N_SINGLE = 4'hD;
  localparam logic [3:0] OE_N_DUAL = 4'hC;
  localparam logic [3:0] OE_N_QUAD = 4'h0;
  // sizes and timing
  localparam int FIFO_DEPTH = 8;
  localparam int CLK_PERIOD_NS = 50;
  localparam int STATUS_WRITE_TIME_NS = 1000000;
  localparam int STATUS_WRITE_CYCLES =
    (STATUS_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // the three status registers travel together
  typedef struct packed {
    logic [7:0] sr3;
    logic [7:0] sr2;
    logic [7:0] sr1;
  } status_s;
  localparam status_s STATUS_RESET = 24'h000000;
  // array read answer
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } mem_rsp_s;
  // frame sequencer states
  typedef enum logic [2:0] {
    ST_CMD, ST_ADDR, ST_DUMMY, ST_STAT, ST_WSR, ST_DATA, ST_DONE, ST_IGNORE
  } state_e;
endpackage

// *** core/flash_front.sv ***
// serial flash instruction front end: status, write enable and read paths
// Operation
// - write enable instruction sets write enable latch
// - instruction bits sampled on rising clock edges
// - volatile enable leaves latch, qualifies next write
// - write disable instruction clears the latch
// - latch clears on reset and operation completion
// - status shifted out msb first, falling edges
// - status read allowed anytime, repeats until deselect
// - only listed status bits are writable
// - lock bits only return to zero at reset
// - non-volatile write runs timed busy cycle
// - volatile write updates fast, no busy
// - soft reset restores stored non-volatile status values
// - sixteen data bits write registers one and two
// - read code plus address, data msb first
// - address increments, streaming until deselect
// - read while busy is ignored
// - normal read only in single-line mode
// - fast read waits eight dummy clocks
// - dual read drives two bits per clock
// - quad read needs quad enable bit
// - dual lanes carry odd and even bits
// - quad lanes carry nibbles, upper first
`timescale 1ns/10ps
`default_nettype none

// byte buffer between array fetch and serial output
module flash_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_flush,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH]; // storage words
  logic [AW:0] wr_q; // write pointer with wrap bit
  logic [AW:0] rd_q; // read pointer with wrap bit
  logic push;
  logic pop;

  // pointer arithmetic relies on a power-of-two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("fifo depth must be a power of two");
  end

  assign o_in_ready = (wr_q - rd_q) != (AW + 1)'(DEPTH);
  assign o_out_valid = wr_q != rd_q;
  assign push = i_in_valid & o_in_ready;
  assign pop = i_out_ready & o_out_valid;
  assign o_out_data = mem_q[rd_q[AW-1:0]];

  // storage has no reset; only written words are ever read
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= i_in_data;
    end
  end

  // pointers; flush empties at once
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else if (i_flush) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + (AW + 1)'(1);
      end
      if (pop) begin
        rd_q <= rd_q + (AW + 1)'(1);
      end
    end
  end
endmodule // flash_fifo

// device-side front end, oversampling the host serial clock
module flash_front #(
  parameter int WSR_CYCLES = flash_front_pkg::STATUS_WRITE_CYCLES,
  parameter int FIFO_WORDS = flash_front_pkg::FIFO_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic [3:0] i_io,
  output logic [3:0] o_io,
  output logic [3:0] o_io_oe_n,
  output logic o_mem_req,
  output logic [23:0] o_mem_addr,
  input wire flash_front_pkg::mem_rsp_s i_mem_rsp,
  input wire logic i_array_busy,
  input wire logic i_array_done,
  input wire logic i_soft_reset,
  output flash_front_pkg::status_s o_status
);
  import flash_front_pkg::*;
  localparam int WW = $clog2(WSR_CYCLES + 1);

  if (WSR_CYCLES < 8) begin : g_bad_wsr
    $error("status write time must be at least eight cycles");
  end

  // synchronisers for pins from the host domain
  logic [1:0] sclk_s_q;
  logic [1:0] cs_s_q;
  logic [3:0] io_s1_q;
  logic [3:0] io_s2_q;
  logic sclk_d_q; // last synchronised clock level
  logic csn_d_q; // last synchronised select level
  logic csn; // synchronised select
  logic si; // synchronised serial input
  logic rise; // host rising edge seen
  logic fall; // host falling edge seen
  logic cs_rise; // end of frame
  // frame sequencer
  state_e state_q;
  state_e dec_state;
  logic [2:0] dec_lanes;
  logic [4:0] cnt_q;
  logic [7:0] code_q;
  logic [7:0] next_byte;
  logic [23:0] addr_q;
  logic [15:0] wdata_q;
  logic [2:0] lanes_q;
  logic dummy_q; // fast variants wait dummy clocks
  // status state
  status_s cur_q; // live status values
  status_s nv_q; // stored non-volatile values
  status_s nx; // status after a write
  status_s view; // status as read out
  logic latch_q; // write enable latch
  logic vwen_q;
  logic wip_q;
  logic [WW-1:0] wip_cnt_q;
  logic busy_all;
  logic done_evt;
  logic wen_set;
  logic latch_clr;
  logic wr_en;
  logic wr_nv;
  logic [7:0] first;
  // output shifter and fetch
  logic [2:0] opos_q;
  logic [7:0] obyte_q;
  logic [7:0] cur_byte;
  logic [7:0] stat_byte;
  logic [3:0] out_q;
  logic [3:0] oe_q;
  logic pop;
  logic fetch_q;
  logic outst_q;
  logic drop_q;
  logic [23:0] faddr_q;
  logic addr_done;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;

  // keep read-only bits, take writable ones from the new byte
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw,
                                       input logic [7:0] mask);
    return (old & ~mask) | (nw & mask);
  endfunction

  // lock bits are one-shot; a volatile write may not unlock either
  function automatic logic [7:0] lock(input logic [7:0] old, input logic [7:0] nw,
                                      input logic vol);
    logic [7:0] r;
    r = nw | (old & LOCK_MASK);
    if (vol) begin
      r[BIT_REG_LOCK] = nw[BIT_REG_LOCK] | old[BIT_REG_LOCK];
    end
    return r;
  endfunction

  // place the top bits of a byte on the lanes in use
  function automatic logic [3:0] lane_bits(input logic [7:0] b, input logic [2:0] lanes);
    case (lanes)
      LANES_1: lane_bits = {2'h0, b[7], 1'b0};
      LANES_2: lane_bits = {2'h0, b[7:6]};
      default: lane_bits = b[7:4];
    endcase
  endfunction

  // which lanes are driven for a given width
  function automatic logic [3:0] lane_oe_n(input logic [2:0] lanes);
    case (lanes)
      LANES_1: lane_oe_n = OE_N_SINGLE;
      LANES_2: lane_oe_n = OE_N_DUAL;
      default: lane_oe_n = OE_N_QUAD;
    endcase
  endfunction

  // two flops before anything reads a pin
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sclk_s_q <= 2'h0;
      cs_s_q <= 2'h3;
      io_s1_q <= 4'h0;
      io_s2_q <= 4'h0;
      sclk_d_q <= 1'b0;
      csn_d_q <= 1'b1;
    end else begin
      sclk_s_q <= {sclk_s_q[0], i_sclk};
      cs_s_q <= {cs_s_q[0], i_cs_n};
      io_s1_q <= i_io;
      io_s2_q <= io_s1_q;
      sclk_d_q <= sclk_s_q[1];
      csn_d_q <= cs_s_q[1];
    end
  end

  assign csn = cs_s_q[1];
  assign si = io_s2_q[0];
  assign rise = ~csn & sclk_s_q[1] & ~sclk_d_q;
  assign fall = ~csn & ~sclk_s_q[1] & sclk_d_q;
  assign cs_rise = csn & ~csn_d_q;
  assign next_byte = {shift8(), si};
  assign busy_all = wip_q | i_array_busy;

  function automatic logic [6:0] shift8();
    return code_q[6:0];
  endfunction

  // decode a completed code; only single-line codes exist here
  always_comb begin
    dec_state = ST_IGNORE;
    dec_lanes = LANES_1;
    case (next_byte)
      CMD_WEN, CMD_WDI, CMD_VWEN: dec_state = ST_DONE;
      CMD_RSR1, CMD_RSR2, CMD_RSR3: dec_state = ST_STAT;
      CMD_WSR1, CMD_WSR2, CMD_WSR3: begin
        if ((latch_q | vwen_q) & ~busy_all) begin
          dec_state = ST_WSR;
        end
      end
      CMD_READ, CMD_FAST: begin
        if (!busy_all) begin
          dec_state = ST_ADDR;
        end
      end
      CMD_DUAL: begin
        if (!busy_all) begin
          dec_state = ST_ADDR;
        end
        dec_lanes = LANES_2;
      end
      CMD_QUAD: begin
        if (!busy_all && cur_q.sr2[BIT_QUAD]) begin
          dec_state = ST_ADDR;
        end
        dec_lanes = LANES_4;
      end
      default: dec_state = ST_IGNORE;
    endcase
  end

  // frame sequencer, advanced on host rising edges
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= ST_CMD;
      cnt_q <= 5'h00;
      code_q <= 8'h00;
      addr_q <= 24'h000000;
      wdata_q <= 16'h0000;
      lanes_q <= LANES_1;
      dummy_q <= 1'b0;
    end else if (csn) begin
      state_q <= ST_CMD;
      cnt_q <= 5'h00;
      code_q <= 8'h00;
    end else if (rise) begin
      case (state_q)
        ST_CMD: begin
          code_q <= next_byte;
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == LAST_CMD_BIT) begin
            cnt_q <= 5'h00;
            state_q <= dec_state;
            lanes_q <= dec_lanes;
            dummy_q <= next_byte != CMD_READ;
          end
        end
        ST_ADDR: begin
          addr_q <= {addr_q[22:0], si};
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == LAST_ADDR_BIT) begin
            cnt_q <= 5'h00;
            state_q <= dummy_q ? ST_DUMMY : ST_DATA;
          end
        end
        ST_DUMMY: begin
          // input during these clocks is ignored
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == LAST_DUMMY) begin
            state_q <= ST_DATA;
          end
        end
        ST_WSR: begin
          wdata_q <= {wdata_q[14:0], si};
          if (cnt_q == TWO_BYTES) begin
            state_q <= ST_IGNORE; // too many bits voids the write
          end else begin
            cnt_q <= cnt_q + 5'h01;
          end
        end
        ST_DONE: state_q <= ST_IGNORE; // extra bits cancel the code
        default: state_q <= state_q;
      endcase
    end
  end

  // status write decode at deselect
  always_comb begin
    wr_en = cs_rise && state_q == ST_WSR &&
            (cnt_q == ONE_BYTE || (cnt_q == TWO_BYTES && code_q == CMD_WSR1));
    wr_nv = ~vwen_q;
    first = (cnt_q == TWO_BYTES) ? wdata_q[15:8] : wdata_q[7:0];
    nx = cur_q;
    case (code_q)
      CMD_WSR1: begin
        nx.sr1 = merge(cur_q.sr1, first, WR_MASK1);
        if (cnt_q == TWO_BYTES) begin
          nx.sr2 = lock(cur_q.sr2, merge(cur_q.sr2, wdata_q[7:0], WR_MASK2), ~wr_nv);
        end
      end
      CMD_WSR2: nx.sr2 = lock(cur_q.sr2, merge(cur_q.sr2, first, WR_MASK2), ~wr_nv);
      CMD_WSR3: nx.sr3 = merge(cur_q.sr3, first, WR_MASK3);
      default: nx = cur_q;
    endcase
  end

  assign done_evt = cs_rise && state_q == ST_DONE;
  assign wen_set = done_evt && code_q == CMD_WEN;
  assign latch_clr = (wip_q && wip_cnt_q == WW'(1)) | i_array_done | i_soft_reset |
                   (done_evt && code_q == CMD_WDI);

  // live status; a soft reset drops volatile values
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cur_q <= STATUS_RESET;
    end else if (i_soft_reset) begin
      cur_q <= nv_q;
    end else if (wr_en) begin
      cur_q <= nx;
    end
  end

  // stored copy follows non-volatile writes, only in the registers written,
  // so volatile values held elsewhere are never committed by accident
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      nv_q <= STATUS_RESET;
    end else if (wr_en && wr_nv) begin
      case (code_q)
        CMD_WSR1: begin
          nv_q.sr1 <= nx.sr1;
          if (cnt_q == TWO_BYTES) begin
            nv_q.sr2 <= nx.sr2;
          end
        end
        CMD_WSR2: nv_q.sr2 <= nx.sr2;
        CMD_WSR3: nv_q.sr3 <= nx.sr3;
        default: nv_q <= nv_q;
      endcase
    end
  end

  // write enable latch; a set in the same cycle as a clear wins
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      latch_q <= 1'b0;
    end else if (wen_set) begin
      latch_q <= 1'b1;
    end else if (latch_clr) begin
      latch_q <= 1'b0;
    end
  end

  // volatile enable holds only until the next status write
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      vwen_q <= 1'b0;
    end else if (done_evt && code_q == CMD_VWEN) begin
      vwen_q <= 1'b1;
    end else if (wr_en || i_soft_reset) begin
      vwen_q <= 1'b0;
    end
  end

  // self-timed non-volatile write cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wip_q <= 1'b0;
      wip_cnt_q <= '0;
    end else if (wr_en && wr_nv) begin
      wip_q <= 1'b1;
      wip_cnt_q <= WW'(WSR_CYCLES);
    end else if (wip_q) begin
      wip_cnt_q <= wip_cnt_q - WW'(1);
      if (wip_cnt_q == WW'(1)) begin
        wip_q <= 1'b0;
      end
    end
  end

  // status as seen by the host
  always_comb begin
    view = cur_q;
    view.sr1[BIT_BUSY] = busy_all;
    view.sr1[BIT_LATCH] = latch_q;
  end
  assign o_status = view;

  // register chosen by the read code, sampled fresh for each byte
  always_comb begin
    case (code_q)
      CMD_RSR2: stat_byte = view.sr2;
      CMD_RSR3: stat_byte = view.sr3;
      default: stat_byte = view.sr1;
    endcase
  end

  // a new byte is taken at each byte boundary; an empty buffer gives stale data
  assign pop = fall && state_q == ST_DATA && opos_q == 3'h0;
  assign cur_byte = (opos_q != 3'h0) ? obyte_q :
                    (state_q == ST_DATA) ? fifo_out_data : stat_byte;

  // output shifter, advanced on host falling edges
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      opos_q <= 3'h0;
      obyte_q <= 8'h00;
      out_q <= 4'h0;
      oe_q <= OE_N_NONE;
    end else if (csn) begin
      opos_q <= 3'h0;
      oe_q <= OE_N_NONE;
    end else if (fall && (state_q == ST_STAT || state_q == ST_DATA)) begin
      out_q <= lane_bits(cur_byte, lanes_q);
      oe_q <= lane_oe_n(lanes_q);
      obyte_q <= cur_byte << lanes_q;
      opos_q <= opos_q + lanes_q; // wraps every byte
    end
  end
  assign o_io = out_q;
  assign o_io_oe_n = oe_q;

  assign addr_done = rise && state_q == ST_ADDR && cnt_q == LAST_ADDR_BIT;
  assign o_mem_req = fetch_q & ~outst_q & fifo_in_ready;
  assign o_mem_addr = faddr_q;

  // array prefetch: one read outstanding, stalls when buffer is full
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fetch_q <= 1'b0;
      outst_q <= 1'b0;
      drop_q <= 1'b0;
      faddr_q <= 24'h000000;
    end else begin
      if (csn) begin
        fetch_q <= 1'b0; // read ends at deselect
      end else if (addr_done) begin
        fetch_q <= 1'b1;
        faddr_q <= {addr_q[22:0], si};
      end
      if (o_mem_req) begin
        outst_q <= 1'b1;
        faddr_q <= faddr_q + 24'h000001;
      end else if (i_mem_rsp.valid) begin
        outst_q <= 1'b0;
      end
      if (i_mem_rsp.valid) begin
        drop_q <= 1'b0;
      end else if (csn && outst_q) begin
        drop_q <= 1'b1; // late answer of a closed frame
      end
    end
  end

  flash_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_WORDS)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_flush(csn),
    .i_in_valid(i_mem_rsp.valid & outst_q & ~drop_q & fetch_q),
    .o_in_ready(fifo_in_ready),
    .i_in_data(i_mem_rsp.data),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(pop),
    .o_out_data(fifo_out_data)
  );

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_nv_write;
    wr_en && wr_nv;
  endsequence

  chk_wen_sets: assert property (wen_set |=> latch_q)
    else $error("write enable did not set latch");
  chk_wdi_clears: assert property (done_evt && code_q == CMD_WDI |=> !latch_q)
    else $error("write disable did not clear latch");
  chk_vwen_keeps: assert property (done_evt && code_q == CMD_VWEN && !latch_clr
                                   |=> latch_q == $past(latch_q) && vwen_q)
    else $error("volatile enable changed latch");
  chk_nv_busy: assert property (s_nv_write |=> wip_q [*8])
    else $error("busy not held after status write");
  chk_vol_fast: assert property (wr_en && !wr_nv && !wip_q && !i_soft_reset
                                 |=> !wip_q && cur_q == $past(nx) && !latch_q)
    else $error("volatile write slow or busy");
  chk_lock_sticky: assert property (!i_soft_reset |=> (($past(cur_q.sr2) & LOCK_MASK)
                                    & ~cur_q.sr2) == 8'h00)
    else $error("lock bit returned to zero");
  chk_read_busy: assert property (rise && state_q == ST_CMD && cnt_q == LAST_CMD_BIT
                                  && next_byte == CMD_READ && busy_all
                                  |=> state_q == ST_IGNORE)
    else $error("read accepted while busy");
  chk_quad_qe: assert property (rise && state_q == ST_CMD && cnt_q == LAST_CMD_BIT
                                && next_byte == CMD_QUAD && !cur_q.sr2[BIT_QUAD]
                                |=> state_q == ST_IGNORE)
    else $error("quad read accepted without enable");
  chk_done_clears: assert property (i_array_done && !wen_set |=> !latch_q)
    else $error("latch kept after completion");
  chk_stat_lane: assert property (fall && state_q == ST_STAT
                                  |=> o_io_oe_n == OE_N_SINGLE)
    else $error("status not on single line");
  chk_wsr_mask: assert property (wr_en |=> ((cur_q.sr3 ^ $past(cur_q.sr3))
                                 & ~WR_MASK3) == 8'h00 || $past(i_soft_reset))
    else $error("read-only bit written");
endmodule // flash_front
`default_nettype wire

// *** verification/flash_front_tb.sv ***
// self-checking bench for the serial flash instruction front end
`timescale 1ns/10ps
`default_nettype none
module flash_front_tb;
  import flash_front_pkg::*;
  localparam int WSRC = 32; // shortened status write time
  logic i_clk, i_rst_n, sclk, cs_n, req, abusy, adone, sreset, latch, bz;
  logic [3:0] h_io, io_w, o_io, oe_n;
  logic [23:0] addr;
  mem_rsp_s rsp;
  status_s st;
  logic [7:0] lf = 8'h49; // lfsr, starts at 73
  logic [7:0] m_sr [3]; // model: live status
  logic [7:0] m_nv [3]; // model: stored status
  logic [7:0] b;
  int miscompares = 0;
  int n_compared = 0;
  // wire level: the device wins where it drives
  assign io_w = (oe_n & h_io) | (~oe_n & o_io);
  flash_host host (.i_clk(i_clk), .i_io(io_w), .o_sclk(sclk), .o_cs_n(cs_n), .o_io(h_io));
  flash_front #(.WSR_CYCLES(WSRC)) uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_sclk(sclk),
    .i_cs_n(cs_n), .i_io(io_w), .o_io(o_io), .o_io_oe_n(oe_n), .o_mem_req(req),
    .o_mem_addr(addr), .i_mem_rsp(rsp), .i_array_busy(abusy), .i_array_done(adone),
    .i_soft_reset(sreset), .o_status(st));
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  function automatic logic [7:0] md(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'hA5;
  endfunction
  // array model: a request taken at a rising edge is answered in the next cycle
  logic req_seen = 1'b0;
  logic [23:0] addr_seen = 24'h000000;
  always @(posedge i_clk) begin
    req_seen <= req;
    addr_seen <= addr;
  end
  always @(negedge i_clk) begin
    rsp.valid = req_seen;
    rsp.data = md(addr_seen);
  end
  function automatic logic [7:0] rnd();
    lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
    return lf;
  endfunction
  task automatic chk(input logic [23:0] s, input logic [23:0] e, input string m);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch at %0t: %s saw %h expected %h", $time, m, s, e);
    end
  endtask
  task automatic stc();
    chk(st, {m_sr[2], m_sr[1], m_sr[0] | {6'h00, latch, bz}}, "status");
  endtask
  task automatic one(input logic [7:0] c);
    host.sel();
    host.put(c, 1'b1);
    host.desel();
  endtask
  // model write: masks, then lock bits that may not fall
  task automatic mwr(input int i, input logic [7:0] d, input bit nv);
    logic [7:0] k;
    logic [7:0] o;
    k = i == 0 ? WR_MASK1 : i == 1 ? WR_MASK2 : WR_MASK3;
    o = m_sr[i];
    m_sr[i] = (o & ~k) | (d & k);
    if (i == 1) m_sr[1] |= o & (nv ? LOCK_MASK : (LOCK_MASK | 8'h01));
    if (nv) m_nv[i] = m_sr[i];
  endtask
  task automatic fin(input bit nv);
    chk(st.sr1[BIT_BUSY], nv, "busy");
    if (nv) repeat (WSRC + 8) @(negedge i_clk);
    latch = 1'b0;
    stc();
  endtask
  task automatic wsr(input int i, input logic [7:0] d, input bit nv);
    one(nv ? CMD_WEN : CMD_VWEN);
    host.sel();
    host.put(i == 0 ? CMD_WSR1 : i == 1 ? CMD_WSR2 : CMD_WSR3, 1'b1);
    host.put(d, 1'b1);
    host.desel();
    mwr(i, d, nv);
    fin(nv);
  endtask
  task automatic rds(input int i);
    host.sel();
    host.put(i == 0 ? CMD_RSR1 : i == 1 ? CMD_RSR2 : CMD_RSR3, 1'b1);
    repeat (2) begin
      host.get(1, b);
      chk(b, m_sr[i] | (i == 0 ? {6'h00, latch, bz} : 8'h00), "sread");
    end
    host.desel();
  endtask
  // code, address, dummy byte unless plain read, then n bytes; a refused read stays undriven
  task automatic rd(input logic [7:0] c, input int ln, input logic [23:0] a, input int n,
    input bit ok);
    host.sel();
    host.put(c, 1'b1);
    for (int i = 2; i >= 0; i--) host.put(a[8*i +: 8], 1'b1);
    if (c != CMD_READ) host.put(8'h00, 1'b0);
    for (int i = 0; i < n; i++) begin
      host.get(ln, b);
      if (ok) chk(b, md(a + 24'(i)), "data");
      if (i == 9) repeat (60) @(negedge i_clk); // host stalls while the buffer fills
    end
    chk(oe_n, !ok ? OE_N_NONE : ln == 1 ? OE_N_SINGLE : ln == 2 ? OE_N_DUAL : OE_N_QUAD,
      "lanes");
    host.desel();
    $display("test read %h done", c);
  endtask
  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #(50 * 80000);
    miscompares++;
    stop_test();
  end
  initial begin
    {i_rst_n, abusy, adone, sreset, latch, bz} = 6'h00;
    m_sr = '{default: 8'h00};
    m_nv = '{default: 8'h00};
    repeat (4) @(negedge i_clk);
    i_rst_n = 1'b1;
    repeat (4) @(negedge i_clk);
    stc();
    one(CMD_WEN);
    latch = 1'b1;
    stc();
    one(CMD_VWEN);
    stc();
    one(CMD_WDI);
    latch = 1'b0;
    stc();
    one(CMD_WEN);
    adone = 1'b1;
    @(negedge i_clk);
    adone = 1'b0;
    repeat (2) @(negedge i_clk);
    stc();
    // the volatile enable from above is still pending; a volatile write uses it up
    wsr(0, rnd(), 1'b0);
    for (int i = 0; i < 3; i++) wsr(i, rnd() & (i == 1 ? 8'hFE : 8'hFF), 1'b1);
    wsr(1, 8'h38, 1'b1);
    wsr(1, 8'h00, 1'b1);
    wsr(0, rnd(), 1'b0);
    for (int i = 0; i < 3; i++) rds(i);
    sreset = 1'b1;
    @(negedge i_clk);
    sreset = 1'b0;
    repeat (2) @(negedge i_clk);
    m_sr = m_nv;
    stc();
    one(CMD_WEN);
    host.sel();
    host.put(CMD_WSR1, 1'b1);
    b = rnd();
    host.put(b, 1'b1);
    mwr(0, b, 1'b1);
    b = (rnd() | 8'h02) & 8'hFE; // quad enable on for the quad read
    host.put(b, 1'b1);
    mwr(1, b, 1'b1);
    host.desel();
    fin(1'b1);
    rd(CMD_READ, 1, {rnd(), rnd(), 8'hFC}, 12, 1'b1);
    rd(CMD_FAST, 1, {rnd(), rnd(), 8'hFE}, 3, 1'b1);
    rd(CMD_DUAL, 2, {rnd(), rnd(), rnd()}, 4, 1'b1);
    rd(CMD_QUAD, 4, {rnd(), rnd(), rnd()}, 4, 1'b1);
    wsr(1, 8'h00, 1'b0);
    rd(CMD_QUAD, 4, 24'h000010, 1, 1'b0);
    abusy = 1'b1;
    bz = 1'b1;
    rds(0);
    rd(CMD_READ, 1, 24'h000020, 1, 1'b0);
    abusy = 1'b0;
    bz = 1'b0;
    rd(8'hA7, 1, 24'h000030, 1, 1'b0);
    host.sel();
    host.put(CMD_WSR3, 1'b1);
    host.put(8'hFF, 1'b1);
    host.desel();
    stc();
    stop_test();
  end
endmodule // flash_front_tb
`default_nettype wire

// *** verification/flash_host.sv ***
// host controller model: serial clock, select and io lines
`timescale 1ns/10ps
`default_nettype none
module flash_host (
  input wire logic i_clk,
  input wire logic [3:0] i_io,
  output logic o_sclk,
  output logic o_cs_n,
  output logic [3:0] o_io
);
  logic rel = 1'b1; // released lines toggle so a stale level never passes
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_io = 4'h5;
  end
  // half of the 400 ns link period; sclk stands low between frames
  task automatic half();
    repeat (4) @(negedge i_clk);
    if (rel) o_io = ~o_io;
  endtask
  task automatic sel();
    o_cs_n = 1'b0;
    half();
  endtask
  // msb first on line zero, set up while sclk is low
  task automatic put(input logic [7:0] b, input logic drv);
    for (int i = 7; i >= 0; i--) begin
      rel = !drv; // dummy clocks run with the lines released
      if (drv) o_io[0] = b[i];
      half();
      o_sclk = 1'b1;
      half();
      o_sclk = 1'b0;
    end
  endtask
  // sampled late in the high phase, well after the device moved its lines
  task automatic get(input int ln, output logic [7:0] b);
    rel = 1'b1;
    for (int i = 0; i < 8 / ln; i++) begin
      half();
      o_sclk = 1'b1;
      half();
      if (ln == 1) b = {b[6:0], i_io[1]};
      else if (ln == 2) b = {b[5:0], i_io[1:0]};
      else b = {b[3:0], i_io};
      o_sclk = 1'b0;
    end
  endtask
  task automatic desel();
    o_cs_n = 1'b1;
    rel = 1'b1;
    repeat (8) @(negedge i_clk);
  endtask
endmodule // flash_host
`default_nettype wire
